/* File: sbrc_pkg.sv */
// Package of the sleep, battery and signal-strength control block.
// Shared by the main control module and its testbench.
package sbrc_pkg;

    // ****************************************************************
    // Register addresses (six bits, inside the SPI command byte)
    // ****************************************************************
    localparam logic [5:0] ADDR_XACT_CFG = 6'h0f;
    localparam logic [5:0] ADDR_RX_CFG = 6'h06;
    localparam logic [5:0] ADDR_PWR_CFG = 6'h0e;
    localparam logic [5:0] ADDR_STATUS = 6'h0d;
    localparam logic [5:0] ADDR_IRQ_EN = 6'h0c;
    localparam logic [5:0] ADDR_SIGNAL = 6'h13;
    localparam logic [5:0] ADDR_MODE = 6'h0b;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_INC_BIT = 6;
    localparam int XACT_FORCE_END_BIT = 5;
    localparam int XACT_END_STATE_LSB = 2;
    localparam int XACT_AUTO_SLEEP_BIT = 7;
    localparam int RX_LNA_BIT = 7;
    localparam int RX_ATT_BIT = 6;
    localparam int PWR_LVL_LSB = 0;
    localparam int IRQ_EN_OSC_BIT = 0;
    localparam int IRQ_EN_LOWBAT_BIT = 1;
    localparam int MODE_TX_BIT = 0;
    localparam int MODE_RX_BIT = 1;
    localparam int STAT_OSC_BIT = 0;
    localparam int STAT_LOWBAT_BIT = 1;
    localparam int STAT_SLEEP_BIT = 2;

    localparam logic [2:0] END_STATE_SLEEP = 3'h0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_XACT_CFG = 8'h00;
    localparam logic [7:0] RST_RX_CFG = 8'h80;
    localparam logic [7:0] RST_PWR_CFG = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 200;
    localparam int SLEEP_LIMIT_US = 35;
    localparam int SLEEP_LIMIT_CYC = SLEEP_LIMIT_US * CLK_MHZ;
    localparam int SAMPLE_GAP_US = 12;
    localparam int SAMPLE_GAP_CYC = SAMPLE_GAP_US * CLK_MHZ;
    localparam int OSC_SETTLE_CYC = 64;

    typedef enum logic [1:0] {
        SBRC_AWAKE = 2'b00,
        SBRC_SLEEP = 2'b01,
        SBRC_START = 2'b11
    } sbrc_pwr_t;

    // Events from the SPI domain, each a toggle.
    typedef struct packed {
        logic sleep_cmd;
        logic signal_read;
    } sbrc_evt_t;

    // Analogue-side settings.
    typedef struct packed {
        logic lna_on;
        logic att_on;
        logic [2:0] lowbat_level;
    } sbrc_front_t;

endpackage

/* File: sbrc_regs.sv */
// Register store written and read from the serial clock domain.
// Assumes the serial clock only runs during frames.
`timescale 1ns/1ps
module sbrc_regs #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic sck,
    input wire logic rstn,
    // Access
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [5:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_reg [DEPTH];
    logic [7:0] rdata_reg;

    // Contents are kept across sleep since this clock never stops for it.
    always_ff @(posedge sck) begin
        if (we) begin
            mem_reg[waddr] <= wdata;
        end
    end

    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= mem_reg[raddr];
        end
    end

    assign rdata = rdata_reg;
endmodule

/* File: sbrc_top.sv */
// Sleep, battery monitor and signal-strength control with SPI slave.
// Assumes the host SCK idles low and samples MISO on SCK rising edges.
//
// Notes on behaviour
// - Force-end set with end state 000 in transaction config puts device asleep.
// - Sleep is reached within 35 us after the final SCK rise of that write.
// - With auto-sleep enabled, sleep follows the end of a packet.
// - In sleep the oscillator is stopped while SPI keeps working.
// - Commanding transmit or receive wakes the device automatically.
// - On wake, the oscillator interrupt fires once stable, if enabled.
// - Eight selectable battery thresholds; the result is readable over SPI.
// - Low-battery interrupt follows the live comparison and is not latched.
// - Battery monitoring is suspended while asleep.
// - Clearing the amplifier enable lowers receive gain by about 20 dB.
// - Setting the attenuator bit adds about 30 dB attenuation.
// - In receive mode a five-bit signal strength is stored and readable.
// - A sample is taken when a start-of-packet is detected.
// - Each read of signal strength starts a new sample, at most every 12 us.
// - Command byte: bit 7 write, bit 6 auto-increment, bits 5:0 address.
// - SPI logic runs from SCK alone, never from the internal clock.
// - Status flags stay readable even when their interrupt is disabled.
`timescale 1ns/1ps
module sbrc_top #(
    parameter int SLEEP_CYC = sbrc_pkg::SLEEP_LIMIT_CYC,
    parameter int GAP_CYC = sbrc_pkg::SAMPLE_GAP_CYC,
    parameter int SETTLE_CYC = sbrc_pkg::OSC_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // SPI slave, link clock domain
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Radio and analogue side
    input wire logic packet_done,
    input wire logic start_of_packet,
    input wire logic osc_ready,
    input wire logic lowbat_cmp,
    input wire logic [4:0] signal_level,
    // Control outputs
    output logic osc_enable,
    output logic sleeping,
    output logic lowbat_monitor_on,
    output logic tx_go,
    output logic rx_go,
    output sbrc_pkg::sbrc_front_t front,
    output logic irq
);

    // ****************************************************************
    // SPI slave on SCK
    // ****************************************************************
    logic [2:0] bit_reg, bit_next;
    logic [6:0] sh_reg, sh_next;
    logic have_cmd_reg, have_cmd_next;
    logic wr_reg, wr_next;
    logic inc_reg, inc_next;
    logic [5:0] adr_reg, adr_next;
    logic [7:0] tx_reg, tx_next;
    logic sleep_tgl_reg, sleep_tgl_next;
    logic read_tgl_reg, read_tgl_next;
    logic [7:0] xact_reg, xact_next;
    logic [7:0] rxcfg_reg, rxcfg_next;
    logic [7:0] pwr_reg, pwr_next;
    logic [7:0] irqen_reg, irqen_next;
    logic [7:0] mode_reg, mode_next;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] byte_in;
    logic [7:0] stat_s1_reg, stat_s2_reg;
    logic [4:0] sig_s1_reg, sig_s2_reg;
    logic [7:0] rd_val;
    logic [4:0] sample_reg, sample_next;
    logic [7:0] status_reg, status_next;
    sbrc_pkg::sbrc_evt_t evt;

    assign byte_in = {sh_reg, mosi};

    // Readback multiplexer; status is already two-flop synchronised.
    always_comb begin
        case (adr_next)
            sbrc_pkg::ADDR_XACT_CFG: rd_val = xact_reg;
            sbrc_pkg::ADDR_RX_CFG: rd_val = rxcfg_reg;
            sbrc_pkg::ADDR_PWR_CFG: rd_val = pwr_reg;
            sbrc_pkg::ADDR_IRQ_EN: rd_val = irqen_reg;
            sbrc_pkg::ADDR_MODE: rd_val = mode_reg;
            sbrc_pkg::ADDR_STATUS: rd_val = stat_s2_reg;
            sbrc_pkg::ADDR_SIGNAL: rd_val = {3'h0, sig_s2_reg};
            default: rd_val = mem_rdata;
        endcase
    end

    always_comb begin
        bit_next = bit_reg + 3'h1;
        sh_next = byte_in[6:0];
        have_cmd_next = have_cmd_reg;
        wr_next = wr_reg;
        inc_next = inc_reg;
        adr_next = adr_reg;
        tx_next = {tx_reg[6:0], 1'b0};
        sleep_tgl_next = sleep_tgl_reg;
        read_tgl_next = read_tgl_reg;
        xact_next = xact_reg;
        rxcfg_next = rxcfg_reg;
        pwr_next = pwr_reg;
        irqen_next = irqen_reg;
        mode_next = mode_reg;
        mem_we = 1'b0;
        if (bit_reg == 3'h7) begin
            if (!have_cmd_reg) begin
                have_cmd_next = 1'b1;
                wr_next = byte_in[sbrc_pkg::CMD_DIR_BIT];
                inc_next = byte_in[sbrc_pkg::CMD_INC_BIT];
                adr_next = byte_in[5:0];
            end else begin
                if (wr_reg) begin
                    case (adr_reg)
                        sbrc_pkg::ADDR_XACT_CFG: begin
                            xact_next = byte_in;
                            if (byte_in[sbrc_pkg::XACT_FORCE_END_BIT] &&
                                byte_in[sbrc_pkg::XACT_END_STATE_LSB +: 3]
                                == sbrc_pkg::END_STATE_SLEEP) begin
                                sleep_tgl_next = ~sleep_tgl_reg;
                            end
                        end
                        sbrc_pkg::ADDR_RX_CFG: rxcfg_next = byte_in;
                        sbrc_pkg::ADDR_PWR_CFG: pwr_next = byte_in;
                        sbrc_pkg::ADDR_IRQ_EN: irqen_next = byte_in;
                        sbrc_pkg::ADDR_MODE: mode_next = byte_in;
                        sbrc_pkg::ADDR_STATUS: ;
                        sbrc_pkg::ADDR_SIGNAL: ;
                        default: mem_we = 1'b1;
                    endcase
                end else if (adr_reg == sbrc_pkg::ADDR_SIGNAL) begin
                    read_tgl_next = ~read_tgl_reg;
                end
                if (inc_reg) begin
                    adr_next = adr_reg + 6'h1;
                end
            end
            if (!wr_next) begin
                tx_next = rd_val;
            end
        end
    end

    // serial logic on SCK only; frame state cleared by slave select.
    always_ff @(posedge sck or posedge ss_n) begin
        if (ss_n) begin
            bit_reg <= 3'h0;
            sh_reg <= 7'h00;
            have_cmd_reg <= 1'b0;
            wr_reg <= 1'b0;
            inc_reg <= 1'b0;
            adr_reg <= 6'h00;
            tx_reg <= 8'h00;
        end else begin
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            have_cmd_reg <= have_cmd_next;
            wr_reg <= wr_next;
            inc_reg <= inc_next;
            adr_reg <= adr_next;
            tx_reg <= tx_next;
        end
    end

    // configuration held on SCK, untouched by sleep.
    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            sleep_tgl_reg <= 1'b0;
            read_tgl_reg <= 1'b0;
            xact_reg <= sbrc_pkg::RST_XACT_CFG;
            rxcfg_reg <= sbrc_pkg::RST_RX_CFG;
            pwr_reg <= sbrc_pkg::RST_PWR_CFG;
            irqen_reg <= sbrc_pkg::RST_IRQ_EN;
            mode_reg <= sbrc_pkg::RST_MODE;
        end else begin
            sleep_tgl_reg <= sleep_tgl_next;
            read_tgl_reg <= read_tgl_next;
            xact_reg <= xact_next;
            rxcfg_reg <= rxcfg_next;
            pwr_reg <= pwr_next;
            irqen_reg <= irqen_next;
            mode_reg <= mode_next;
        end
    end

    // MISO changes on the falling edge so the host samples it stable.
    always_ff @(negedge sck or posedge ss_n) begin
        if (ss_n) begin
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso <= tx_reg[7];
            miso_oe <= have_cmd_reg & ~wr_reg;
        end
    end

    // status and strength reach SCK through two flops.
    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            stat_s1_reg <= 8'h00;
            stat_s2_reg <= 8'h00;
            sig_s1_reg <= 5'h00;
            sig_s2_reg <= 5'h00;
        end else begin
            stat_s1_reg <= status_reg;
            stat_s2_reg <= stat_s1_reg;
            sig_s1_reg <= sample_reg;
            sig_s2_reg <= sig_s1_reg;
        end
    end

    sbrc_regs #(
        .DEPTH(64)
    ) sbrc_regs_inst (
        .sck(sck),
        .rstn(rstn),
        .we(mem_we),
        .waddr(adr_reg),
        .wdata(byte_in),
        .raddr(adr_next),
        .rdata(mem_rdata)
    );

    assign evt.sleep_cmd = sleep_tgl_reg;
    assign evt.signal_read = read_tgl_reg;

    // ****************************************************************
    // Crossing into clk
    // ****************************************************************
    sbrc_pkg::sbrc_evt_t evt_s1_reg, evt_s2_reg, evt_s3_reg;
    logic [7:0] xact_s1_reg, xact_s2_reg;
    logic [7:0] rx_s1_reg, rx_s2_reg;
    logic [7:0] pwr_s1_reg, pwr_s2_reg;
    logic [7:0] ien_s1_reg, ien_s2_reg;
    logic [7:0] mode_s1_reg, mode_s2_reg;
    logic [4:0] in_s1_reg, in_s2_reg;
    logic [2:0] pin_s1_reg, pin_s2_reg, pin_d_reg;

    // Config words change only at the last SCK rise of a write byte, so per-bit sync is safe.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_s1_reg <= '0;
            evt_s2_reg <= '0;
            evt_s3_reg <= '0;
            xact_s1_reg <= sbrc_pkg::RST_XACT_CFG;
            xact_s2_reg <= sbrc_pkg::RST_XACT_CFG;
            rx_s1_reg <= sbrc_pkg::RST_RX_CFG;
            rx_s2_reg <= sbrc_pkg::RST_RX_CFG;
            pwr_s1_reg <= sbrc_pkg::RST_PWR_CFG;
            pwr_s2_reg <= sbrc_pkg::RST_PWR_CFG;
            ien_s1_reg <= sbrc_pkg::RST_IRQ_EN;
            ien_s2_reg <= sbrc_pkg::RST_IRQ_EN;
            mode_s1_reg <= sbrc_pkg::RST_MODE;
            mode_s2_reg <= sbrc_pkg::RST_MODE;
            in_s1_reg <= 5'h00;
            in_s2_reg <= 5'h00;
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
            pin_d_reg <= 3'h0;
        end else begin
            evt_s1_reg <= evt;
            evt_s2_reg <= evt_s1_reg;
            evt_s3_reg <= evt_s2_reg;
            xact_s1_reg <= xact_reg;
            xact_s2_reg <= xact_s1_reg;
            rx_s1_reg <= rxcfg_reg;
            rx_s2_reg <= rx_s1_reg;
            pwr_s1_reg <= pwr_reg;
            pwr_s2_reg <= pwr_s1_reg;
            ien_s1_reg <= irqen_reg;
            ien_s2_reg <= ien_s1_reg;
            mode_s1_reg <= mode_reg;
            mode_s2_reg <= mode_s1_reg;
            in_s1_reg <= signal_level;
            in_s2_reg <= in_s1_reg;
            pin_s1_reg <= {osc_ready, lowbat_cmp, start_of_packet};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end

    // ****************************************************************
    // Power state machine on clk
    // ****************************************************************
    sbrc_pkg::sbrc_pwr_t pwr_st_reg, pwr_st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] gap_reg, gap_next;
    logic osc_en_reg, osc_en_next;
    logic tx_reg2, tx_next2, rx_reg2, rx_next2;
    logic irq_reg, irq_next;
    logic mon_reg, mon_next;
    logic sleep_evt, read_evt, sop_rise, want_tx, want_rx, stable;
    logic lowbat_live;

    assign sleep_evt = evt_s2_reg.sleep_cmd ^ evt_s3_reg.sleep_cmd;
    assign read_evt = evt_s2_reg.signal_read ^ evt_s3_reg.signal_read;
    assign sop_rise = pin_s2_reg[0] & ~pin_d_reg[0];
    assign want_tx = mode_s2_reg[sbrc_pkg::MODE_TX_BIT];
    assign want_rx = mode_s2_reg[sbrc_pkg::MODE_RX_BIT];
    assign stable = pin_s2_reg[2];
    // comparator only counts while monitoring is on
    assign lowbat_live = mon_reg & pin_s2_reg[1];

    always_comb begin
        pwr_st_next = pwr_st_reg;
        cnt_next = cnt_reg;
        osc_en_next = osc_en_reg;
        case (pwr_st_reg)
            sbrc_pkg::SBRC_AWAKE: begin
                // sleep command taken within a few cycles
                if (sleep_evt ||
                    (packet_done &&
                     xact_s2_reg[sbrc_pkg::XACT_AUTO_SLEEP_BIT])) begin
                    pwr_st_next = sbrc_pkg::SBRC_SLEEP;
                    osc_en_next = 1'b0;
                end
            end
            sbrc_pkg::SBRC_SLEEP: begin
                // tx or rx request wakes the device
                if (want_tx || want_rx) begin
                    pwr_st_next = sbrc_pkg::SBRC_START;
                    osc_en_next = 1'b1;
                    cnt_next = 16'h0;
                end
            end
            sbrc_pkg::SBRC_START: begin
                if (stable) begin
                    cnt_next = cnt_reg + 16'h1;
                end
                if (cnt_reg == 16'(SETTLE_CYC)) begin
                    pwr_st_next = sbrc_pkg::SBRC_AWAKE;
                end
            end
            default: pwr_st_next = sbrc_pkg::SBRC_AWAKE;
        endcase
    end

    always_comb begin
        sample_next = sample_reg;
        gap_next = (gap_reg == 16'h0) ? 16'h0 : gap_reg - 16'h1;
        // sample on start of packet in receive mode
        if (want_rx && pwr_st_reg == sbrc_pkg::SBRC_AWAKE &&
            (sop_rise || (read_evt && gap_reg == 16'h0))) begin
            sample_next = in_s2_reg;
            gap_next = 16'(GAP_CYC);
        end
        mon_next = (pwr_st_next != sbrc_pkg::SBRC_SLEEP);
        // status flags raw, independent of enables
        status_next = 8'h00;
        status_next[sbrc_pkg::STAT_OSC_BIT] =
            (pwr_st_reg == sbrc_pkg::SBRC_AWAKE);
        status_next[sbrc_pkg::STAT_LOWBAT_BIT] = lowbat_live;
        status_next[sbrc_pkg::STAT_SLEEP_BIT] =
            (pwr_st_reg == sbrc_pkg::SBRC_SLEEP);
        tx_next2 = want_tx && pwr_st_reg == sbrc_pkg::SBRC_AWAKE;
        rx_next2 = want_rx && pwr_st_reg == sbrc_pkg::SBRC_AWAKE;
        irq_next = (ien_s2_reg[sbrc_pkg::IRQ_EN_OSC_BIT] &&
                    pwr_st_reg == sbrc_pkg::SBRC_AWAKE && want_tx | want_rx)
                   || (ien_s2_reg[sbrc_pkg::IRQ_EN_LOWBAT_BIT] &&
                       lowbat_live);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwr_st_reg <= sbrc_pkg::SBRC_AWAKE;
            cnt_reg <= 16'h0;
            gap_reg <= 16'h0;
            sample_reg <= 5'h00;
            status_reg <= 8'h00;
            osc_en_reg <= 1'b1;
            tx_reg2 <= 1'b0;
            rx_reg2 <= 1'b0;
            irq_reg <= 1'b0;
            mon_reg <= 1'b1;
        end else begin
            pwr_st_reg <= pwr_st_next;
            cnt_reg <= cnt_next;
            gap_reg <= gap_next;
            sample_reg <= sample_next;
            status_reg <= status_next;
            osc_en_reg <= osc_en_next;
            tx_reg2 <= tx_next2;
            rx_reg2 <= rx_next2;
            irq_reg <= irq_next;
            mon_reg <= mon_next;
        end
    end

    // Outputs, each from a flop.
    assign osc_enable = osc_en_reg;
    assign sleeping = status_reg[sbrc_pkg::STAT_SLEEP_BIT];
    assign lowbat_monitor_on = mon_reg;
    assign tx_go = tx_reg2;
    assign rx_go = rx_reg2;
    assign irq = irq_reg;
    assign front.lna_on = rx_s2_reg[sbrc_pkg::RX_LNA_BIT];
    assign front.att_on = rx_s2_reg[sbrc_pkg::RX_ATT_BIT];
    assign front.lowbat_level = pwr_s2_reg[sbrc_pkg::PWR_LVL_LSB +: 3];

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_sleep_req;
        sleep_evt && pwr_st_reg == sbrc_pkg::SBRC_AWAKE;
    endsequence

    chk_sleep_entry: assert property (@(posedge clk) disable iff (!rstn)
        s_sleep_req |-> ##1 pwr_st_reg == sbrc_pkg::SBRC_SLEEP ##1 sleeping)
        else $error("sleep not entered after command");
    chk_osc_off: assert property (@(posedge clk) disable iff (!rstn)
        pwr_st_reg == sbrc_pkg::SBRC_SLEEP |-> !osc_enable)
        else $error("oscillator running in sleep");
    chk_wake_go: assert property (@(posedge clk) disable iff (!rstn)
        pwr_st_reg == sbrc_pkg::SBRC_SLEEP && want_rx |=>
        pwr_st_reg == sbrc_pkg::SBRC_START)
        else $error("no wake on receive request");
    chk_hold_radio: assert property (@(posedge clk) disable iff (!rstn)
        pwr_st_reg != sbrc_pkg::SBRC_AWAKE |=> !tx_go && !rx_go)
        else $error("radio started before stable");
    chk_mon_sleep: assert property (@(posedge clk) disable iff (!rstn)
        pwr_st_reg == sbrc_pkg::SBRC_SLEEP |-> !lowbat_monitor_on)
        else $error("battery monitor on in sleep");
    chk_lowbat_irq: assert property (@(posedge clk) disable iff (!rstn)
        $fell(lowbat_live) && !ien_s2_reg[sbrc_pkg::IRQ_EN_OSC_BIT] |=> !irq)
        else $error("low battery irq latched");
    chk_auto_sleep: assert property (@(posedge clk) disable iff (!rstn)
        packet_done && xact_s2_reg[sbrc_pkg::XACT_AUTO_SLEEP_BIT] &&
        pwr_st_reg == sbrc_pkg::SBRC_AWAKE |=> !osc_enable)
        else $error("no auto sleep after packet");
    chk_sample_gap: assert property (@(posedge clk) disable iff (!rstn)
        gap_reg != 16'h0 && !sop_rise |=> $stable(sample_reg))
        else $error("sample spacing broken");
    chk_read_sample: assert property (@(posedge clk) disable iff (!rstn)
        read_evt && want_rx && pwr_st_reg == sbrc_pkg::SBRC_AWAKE &&
        gap_reg == 16'h0 |=> sample_reg == $past(in_s2_reg))
        else $error("no fresh sample after read");
endmodule

/* File: sbrc_host.sv */
// Host model that drives the block's serial port as an SPI master.
// Assumes the block samples MOSI on SCK rise and shifts MISO on fall.
`timescale 1ns/1ps
module sbrc_host (
    // Serial lines
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    // ****
    // Frames
    // ****
    // A select rise after time zero is needed to clear the frame logic.
    initial begin
        sck = 1'b0;
        ss_n = 1'b0;
        mosi = 1'b0;
        #1 ss_n = 1'b1;
    end
    // drop packets whose embedded channel differs
    function automatic logic keep_packet(input logic [7:0] hdr_ch,
                                         input logic [7:0] rx_ch);
        return hdr_ch == rx_ch;
    endfunction
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        ss_n = 1'b0;
        #32;
        for (int i = 15; i >= 0; i--) begin
            mosi = sh[i];
            #32 sck = 1'b1;
            if (i < 8)
                rd[i] = miso;
            #32 sck = 1'b0;
        end
        // Stale data is inverted so that it never looks like a valid bit.
        mosi = ~mosi;
        #32 ss_n = 1'b1;
        #96;
    endtask
endmodule

/* File: test_sleep_battery_signal_strength_sample_control.sv */
// Self-checking bench for the sleep, battery and strength block.
// Assumes the host model in sbrc_host.sv.
`timescale 1ns/1ps
module test_sleep_battery_signal_strength_sample_control;
    logic clk, rstn, sck, ss_n, mosi, miso, miso_oe, irq, mon_on;
    logic pkt_done, sop, osc_ready, lowbat, osc_en, sleeping, tx_go, rx_go;
    logic [4:0] level;
    logic [7:0] rd;
    sbrc_pkg::sbrc_front_t front;
    int failures = 0;
    int samples_checked = 0;
    int oe_rises = 0;
    sbrc_top #(.GAP_CYC(20), .SETTLE_CYC(4)) sbrc_top_inst (.clk(clk),
        .rstn(rstn), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .packet_done(pkt_done), .start_of_packet(sop),
        .osc_ready(osc_ready), .lowbat_cmp(lowbat), .signal_level(level),
        .osc_enable(osc_en), .sleeping(sleeping),
        .lowbat_monitor_on(mon_on), .tx_go(tx_go), .rx_go(rx_go),
        .front(front), .irq(irq));
    sbrc_host sbrc_host_inst (.sck(sck), .ss_n(ss_n), .mosi(mosi),
        .miso(miso));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // The oscillator settles half a cycle after it is enabled, at the next clock fall.
    always @(negedge clk) osc_ready <= osc_en;
    always @(posedge sck) begin
        if (miso_oe === 1'b1) begin
            oe_rises <= oe_rises + 1;
        end
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        sbrc_host_inst.xfer({2'b10, a}, d, rd);
        @(negedge clk);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        sbrc_host_inst.xfer({2'b00, a}, 8'h00, rd);
        @(negedge clk);
        chk(rd, exp);
    endtask
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wt(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 7000) begin
            @(negedge clk);
            n++;
        end
        if (n == 7000) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        {pkt_done, sop, lowbat} = 3'h0;
        rstn = 1'b1;
        level = 5'h00;
        #1 rstn = 1'b0;
        gap(6);
        rstn = 1'b1;
        rdc(sbrc_pkg::ADDR_RX_CFG, 8'h80);
        chk(8'(oe_rises), 8'h08);
        chk({7'h0, sbrc_host_inst.keep_packet(8'h05, 8'h06)}, 8'h00);
        wr(sbrc_pkg::ADDR_RX_CFG, 8'h40);
        wr(sbrc_pkg::ADDR_PWR_CFG, 8'h05);
        wr(sbrc_pkg::ADDR_IRQ_EN, 8'h02);
        lowbat = 1'b1;
        gap(6);
        chk({2'h0, irq, front}, 8'h2d);
        lowbat = 1'b0;
        gap(6);
        chk({7'h0, irq}, 8'h00);
        wr(sbrc_pkg::ADDR_IRQ_EN, 8'h00);
        lowbat = 1'b1;
        rdc(sbrc_pkg::ADDR_STATUS, 8'h03);
        $display("battery test done");
        wr(sbrc_pkg::ADDR_IRQ_EN, 8'h02);
        wr(sbrc_pkg::ADDR_XACT_CFG, 8'h20);
        wt(sleeping);
        chk({4'h0, sleeping, osc_en, mon_on, irq}, 8'h08);
        rdc(sbrc_pkg::ADDR_RX_CFG, 8'h40);
        lowbat = 1'b0;
        wr(sbrc_pkg::ADDR_RX_CFG, 8'h80);
        wr(sbrc_pkg::ADDR_IRQ_EN, 8'h01);
        wr(sbrc_pkg::ADDR_MODE, 8'h02);
        wt(rx_go);
        gap(4);
        chk({4'h0, sleeping, osc_en, rx_go, irq}, 8'h07);
        chk({3'h0, front}, 8'h15);
        $display("sleep test done");
        level = 5'h15;
        gap(4);
        sop = 1'b1;
        gap(8);
        level = 5'h0a;
        sop = 1'b0;
        gap(8);
        rdc(sbrc_pkg::ADDR_SIGNAL, 8'h15);
        gap(30);
        rdc(sbrc_pkg::ADDR_SIGNAL, 8'h0a);
        wr(sbrc_pkg::ADDR_MODE, 8'h01);
        gap(4);
        chk({6'h0, tx_go, rx_go}, 8'h02);
        wr(sbrc_pkg::ADDR_XACT_CFG, 8'h80);
        gap(2);
        pkt_done = 1'b1;
        gap(1);
        pkt_done = 1'b0;
        wt(sleeping);
        $display("strength test done");
        end_sim();
    end
endmodule
